// ==== uart_baud_pkg.sv ====
package uart_baud_pkg;

   // ==========================================================
   // Register byte addresses
   // ==========================================================
   localparam logic [31:0] OFS_SHARED_LOW   = 32'hE000C000; // Divisor low, or receive/transmit data
   localparam logic [31:0] OFS_SHARED_HIGH  = 32'hE000C004; // Divisor high, or interrupt enable
   localparam logic [31:0] OFS_LINE_CONTROL = 32'hE000C00C; // Line control register
   localparam logic [31:0] OFS_FRAC_PRESC   = 32'hE000C028; // Fractional prescaler register
   localparam logic [31:0] OFS_BAUD_STATUS  = 32'hE000C040; // Generator status, read only

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int DIV_ACCESS_POS   = 7;  // Divisor access bit in line control
   localparam int FRAC_ADD_LSB     = 0;  // Add value, bits 3:0
   localparam int FRAC_ADD_MSB     = 3;
   localparam int FRAC_MUL_LSB     = 4;  // Multiplier, bits 7:4
   localparam int FRAC_MUL_MSB     = 7;
   localparam int STAT_COUNT_LSB   = 0;  // Divider counter, bits 15:0
   localparam int STAT_COUNT_MSB   = 15;
   localparam int STAT_FRAC_ON_POS = 16; // Fractional division active
   localparam int STAT_STALL_POS   = 17; // Prescaler in a stall cycle

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0]  RST_DIV_LOW      = 8'h01;
   localparam logic [7:0]  RST_DIV_HIGH     = 8'h00;
   localparam logic [7:0]  RST_LINE_CONTROL = 8'h00;
   localparam logic [3:0]  RST_FRAC_ADD     = 4'h0;
   localparam logic [3:0]  RST_FRAC_MUL     = 4'h1;
   localparam logic [15:0] DIV_ZERO         = 16'h0000;
   localparam logic [15:0] DIV_ONE          = 16'h0001;
   localparam logic [4:0]  ACC_ZERO         = 5'h00;

endpackage

// ==== frac_prescaler.sv ====
`timescale 1ns/1ps

// ==========================================================
// Fractional prescaler
// ==========================================================
// Emits a one-cycle enable at a rate of mul/(mul+add) of the
// peripheral clock; each pulse adds the add value to an
// accumulator and a sum reaching the multiplier inserts one
// stall cycle.
module frac_prescaler (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       reset,
   // Settings
   input  wire logic [3:0] frac_add_value,
   input  wire logic [3:0] frac_multiplier,
   // Output enable
   output logic            prescale_tick,
   output logic            stalled
);

   logic [4:0] acc_r;      // Fraction accumulator
   logic [4:0] acc_nxt;
   logic       stall_r;    // Current cycle withheld
   logic       stall_nxt;
   logic [4:0] sum;        // Accumulator plus add value
   logic       wrap;       // Sum reached the multiplier
   logic       bypass;     // Add value zero

   // Next-state terms
   assign bypass    = (frac_add_value == 4'h0);
   assign sum       = acc_r + {1'b0, frac_add_value};
   assign wrap      = !bypass && (sum >= {1'b0, frac_multiplier});
   assign stall_nxt = !stall_r && wrap;
   assign acc_nxt   = bypass ? uart_baud_pkg::ACC_ZERO :
                      stall_r ? acc_r :
                      wrap ? (sum - {1'b0, frac_multiplier}) : sum;

   // Pulse on every cycle that is not a stall
   assign prescale_tick = !stall_r;
   assign stalled       = stall_r;

   // Accumulator and stall flag
   always_ff @(posedge clock) begin
      if (reset) begin
         acc_r   <= uart_baud_pkg::ACC_ZERO;
         stall_r <= 1'b0;
      end else begin
         acc_r   <= acc_nxt;
         stall_r <= stall_nxt;
      end
   end

endmodule

// ==== uart_fractional_baud_generator.sv ====
`timescale 1ns/1ps

module uart_fractional_baud_generator (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // Register port
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_strobe,
   input  wire logic        rd_strobe,
   output logic      [31:0] rdata,
   // Receive buffer side
   output logic             rbr_read,
   input  wire logic [7:0]  rbr_data,
   // Transmit holding side
   output logic             thr_write,
   output logic      [7:0]  thr_data,
   // Interrupt enable side
   output logic             irq_enable_write,
   output logic      [9:0]  irq_enable_data,
   input  wire logic [9:0]  irq_enable_rdata,
   // Line settings to the character logic
   output logic      [7:0]  line_control,
   // Baud enables
   output logic             prescale_tick,
   output logic             baud16_tick
);

   // ==========================================================
   // Register storage
   // ==========================================================
   logic [7:0]  div_low_r;        // Low divisor byte
   logic [7:0]  div_high_r;       // High divisor byte
   logic [7:0]  line_ctrl_r;      // Line control byte
   logic [3:0]  frac_add_r;       // Fractional add value
   logic [3:0]  frac_mul_r;       // Fractional multiplier
   logic [31:0] rdata_r;          // Read answer
   logic [31:0] rdata_nxt;
   logic        thr_write_r;      // Transmit write pulse
   logic [7:0]  thr_data_r;       // Transmit byte
   logic        ier_write_r;      // Interrupt enable write pulse
   logic [9:0]  ier_data_r;       // Interrupt enable value

   // ==========================================================
   // Divider state
   // ==========================================================
   logic [15:0] div_count_r;      // Prescaled pulses left
   logic [15:0] div_count_nxt;
   logic        baud16_r;         // Sampling enable
   logic        baud16_nxt;
   logic [15:0] divisor_raw;      // Concatenated divisor
   logic [15:0] divisor_eff;      // Divisor with zero guard
   logic        div_expire;       // Counter at its last pulse
   logic        presc_tick;       // Enable from prescaler
   logic        presc_stall;      // Prescaler withholding

   // ==========================================================
   // Address decode
   // ==========================================================
   logic        div_access;       // Divisor access bit
   logic        hit_low;          // Shared low offset
   logic        hit_high;         // Shared high offset
   logic        hit_lcr;          // Line control offset
   logic        hit_frac;         // Fractional offset
   logic        hit_stat;         // Status offset
   // Decoded strobes
   logic        wr_div_low;       // Divisor low write
   logic        wr_div_high;      // Divisor high write
   logic        wr_thr;           // Transmit byte write
   logic        wr_ier;           // Enable register write
   logic        wr_lcr;           // Line control write
   logic        wr_frac;          // Fractional register write
   logic        rd_rbr;           // Receive byte read
   logic [31:0] frac_word;        // Fractional register view
   logic [31:0] stat_word;        // Status register view
   logic [31:0] low_word;         // Shared low read view
   logic [31:0] high_word;        // Shared high read view

   // Access bit taken from the stored line control byte
   assign div_access = line_ctrl_r[uart_baud_pkg::DIV_ACCESS_POS];
   // Whole-word compares; short aliases of an offset miss
   assign hit_low    = (addr == uart_baud_pkg::OFS_SHARED_LOW);
   assign hit_high   = (addr == uart_baud_pkg::OFS_SHARED_HIGH);
   assign hit_lcr    = (addr == uart_baud_pkg::OFS_LINE_CONTROL);
   assign hit_frac   = (addr == uart_baud_pkg::OFS_FRAC_PRESC);
   assign hit_stat   = (addr == uart_baud_pkg::OFS_BAUD_STATUS);

   // Divisor bytes reachable only with the access bit set
   assign wr_div_low  = wr_strobe && hit_low && div_access;
   assign wr_div_high = wr_strobe && hit_high && div_access;
   // Access bit clear: data and enable registers take the offsets
   assign wr_thr      = wr_strobe && hit_low && !div_access;
   assign wr_ier      = wr_strobe && hit_high && !div_access;
   // Receive pop only on a read with the access bit clear
   assign rd_rbr      = rd_strobe && hit_low && !div_access;
   // Line control always reachable, or the access bit could stick
   assign wr_lcr      = wr_strobe && hit_lcr;
   // No gating on the fractional register
   assign wr_frac     = wr_strobe && hit_frac;

   // ==========================================================
   // Read views
   // ==========================================================
   // Reserved upper bits of the fractional word read zero
   assign frac_word = {24'h000000, frac_mul_r, frac_add_r};

   // Shared offsets follow the access bit
   assign low_word  = div_access ? {24'h000000, div_low_r}
                                 : {24'h000000, rbr_data};
   // High offset carries the ten enable bits when closed
   assign high_word = div_access ? {24'h000000, div_high_r}
                                 : {22'h000000, irq_enable_rdata};

   // Live generator state
   // Counter, fraction on and stall flag, for debugging only
   always_comb begin
      stat_word = 32'h00000000;
      stat_word[uart_baud_pkg::STAT_COUNT_MSB:uart_baud_pkg::STAT_COUNT_LSB] = div_count_r;
      stat_word[uart_baud_pkg::STAT_FRAC_ON_POS] = (frac_add_r != 4'h0);
      stat_word[uart_baud_pkg::STAT_STALL_POS]   = presc_stall;
   end

   // Read mux; unmapped or idle gives zero
   // A write strobe alone leaves the answer at zero
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (rd_strobe) begin
         if (hit_low) begin
            rdata_nxt = low_word;
         end else if (hit_high) begin
            rdata_nxt = high_word;
         end else if (hit_lcr) begin
            rdata_nxt = {24'h000000, line_ctrl_r};
         end else if (hit_frac) begin
            rdata_nxt = frac_word;
         end else if (hit_stat) begin
            rdata_nxt = stat_word;
         end else begin
            rdata_nxt = 32'h00000000;
         end
      end
   end

   // ==========================================================
   // Register writes
   // ==========================================================
   // Divisor bytes
   // Each byte written on its own; no pairing lock
   always_ff @(posedge clock) begin
      if (reset) begin
         div_low_r  <= uart_baud_pkg::RST_DIV_LOW;
         div_high_r <= uart_baud_pkg::RST_DIV_HIGH;
      end else begin
         if (wr_div_low) begin
            div_low_r <= wdata[7:0];
         end
         if (wr_div_high) begin
            div_high_r <= wdata[7:0];
         end
      end
   end

   // Line control byte
   // Bit seven opens the divisor bytes at the shared offsets
   always_ff @(posedge clock) begin
      if (reset) begin
         line_ctrl_r <= uart_baud_pkg::RST_LINE_CONTROL;
      end else if (wr_lcr) begin
         line_ctrl_r <= wdata[7:0];
      end
   end

   // Fractional fields; reset leaves the fraction off
   // No access gating; writable at any time
   always_ff @(posedge clock) begin
      if (reset) begin
         frac_add_r <= uart_baud_pkg::RST_FRAC_ADD;
         frac_mul_r <= uart_baud_pkg::RST_FRAC_MUL;
      end else if (wr_frac) begin
         // Upper word bits are not stored
         frac_add_r <= wdata[uart_baud_pkg::FRAC_ADD_MSB:uart_baud_pkg::FRAC_ADD_LSB];
         frac_mul_r <= wdata[uart_baud_pkg::FRAC_MUL_MSB:uart_baud_pkg::FRAC_MUL_LSB];
      end
   end

   // Forwarded writes to transmit and enable registers
   // Data bytes hold after the pulse until the next such write
   always_ff @(posedge clock) begin
      if (reset) begin
         thr_write_r <= 1'b0;
         thr_data_r  <= 8'h00;
         ier_write_r <= 1'b0;
         ier_data_r  <= 10'h000;
      end else begin
         thr_write_r <= wr_thr;
         ier_write_r <= wr_ier;
         if (wr_thr) begin
            thr_data_r <= wdata[7:0];
         end
         if (wr_ier) begin
            ier_data_r <= wdata[9:0];
         end
      end
   end

   // Read answer, one cycle after the strobe
   // Cleared when idle so a stale answer never lingers
   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_r <= 32'h00000000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // Fractional prescaler
   // ==========================================================
   // Mis-set multiplier or add value gives an undefined rate only
   // No lock-up either way: the stall flag never holds two cycles
   // Fields feed straight in; a mid-frame change may bend one period
   frac_prescaler u_frac_prescaler (
      .clock           (clock),
      .reset           (reset),
      .frac_add_value  (frac_add_r),
      .frac_multiplier (frac_mul_r),
      .prescale_tick   (presc_tick),
      .stalled         (presc_stall)
   );

   // ==========================================================
   // Integer divisor stage
   // ==========================================================
   // High byte above low byte
   assign divisor_raw = {div_high_r, div_low_r};
   // Zero treated as one so the counter never stalls
   assign divisor_eff = (divisor_raw == uart_baud_pkg::DIV_ZERO) ?
                        uart_baud_pkg::DIV_ONE : divisor_raw;
   // Last prescaled pulse of the period; also catches a count of zero
   assign div_expire  = (div_count_r <= uart_baud_pkg::DIV_ONE);

   // Reload on expiry, count prescaled pulses otherwise
   // A new divisor lands at the next reload; a count already above
   // the new value runs down to one first, so no period is cut short
   // Stall cycles of the prescaler leave the count untouched
   always_comb begin
      div_count_nxt = div_count_r;
      baud16_nxt    = 1'b0;
      if (presc_tick) begin
         if (div_expire) begin
            div_count_nxt = divisor_eff;
            baud16_nxt    = 1'b1;
         end else begin
            div_count_nxt = div_count_r - uart_baud_pkg::DIV_ONE;
         end
      end
   end

   // Counter and sampling enable
   // Reset count of one gives a first enable right after reset
   always_ff @(posedge clock) begin
      if (reset) begin
         div_count_r <= uart_baud_pkg::DIV_ONE;
         baud16_r    <= 1'b0;
      end else begin
         div_count_r <= div_count_nxt;
         baud16_r    <= baud16_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   // Register port answer
   assign rdata            = rdata_r;
   // Receive pop is combinational, in the strobe cycle itself
   assign rbr_read         = rd_rbr;
   // Forwarded writes, one cycle after the strobe
   assign thr_write        = thr_write_r;
   assign thr_data         = thr_data_r;
   assign irq_enable_write = ier_write_r;
   assign irq_enable_data  = ier_data_r;
   // Settings and enables for the character logic
   assign line_control     = line_ctrl_r;
   assign prescale_tick    = presc_tick;
   assign baud16_tick      = baud16_r;

endmodule

// ==== uart_baud_props.sv ====
`timescale 1ns/1ps

// ==========================================================
// Port checker for the baud generator
// ==========================================================
module uart_baud_props (
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // Register port
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic        wr_strobe,
   input wire logic        rd_strobe,
   input wire logic [31:0] rdata,
   // Data and line sides
   input wire logic        rbr_read,
   input wire logic [7:0]  rbr_data,
   input wire logic        thr_write,
   input wire logic [7:0]  thr_data,
   input wire logic [7:0]  line_control,
   input wire logic        irq_enable_write,
   input wire logic [9:0]  irq_enable_data,
   // Baud enables
   input wire logic        prescale_tick,
   input wire logic        baud16_tick
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);

   logic [3:0] frac_add_r;                                     // Shadow of the written add value
   wire        div_open = line_control[uart_baud_pkg::DIV_ACCESS_POS]; // Divisor access bit
   wire        low_hit = addr == uart_baud_pkg::OFS_SHARED_LOW;    // Shared low offset
   wire [7:0]  wbyte   = wdata[7:0];                           // Written byte

   // Follow writes of the add value
   always_ff @(posedge clock) begin
      if (reset) begin
         frac_add_r <= 4'h0;
      end else if (wr_strobe && addr == uart_baud_pkg::OFS_FRAC_PRESC) begin
         frac_add_r <= wdata[3:0];
      end
   end

   property p_rbr_map;
      rd_strobe && low_hit |-> rbr_read == !div_open;
   endproperty
   a_rbr_map: assert property (p_rbr_map) else $error("receive read gating wrong");
   property p_rbr_data;
      rbr_read |=> rdata[7:0] == $past(rbr_data);
   endproperty
   a_rbr_data: assert property (p_rbr_data) else $error("receive byte not returned");
   property p_thr_map;
      wr_strobe && low_hit && !div_open |=> thr_write && thr_data == $past(wbyte);
   endproperty
   a_thr_map: assert property (p_thr_map) else $error("transmit write not passed on");
   property p_no_thr_open;
      wr_strobe && low_hit && div_open |=> !thr_write;
   endproperty
   a_no_thr_open: assert property (p_no_thr_open) else $error("transmit write while divisor open");
   property p_ier_map;
      wr_strobe && addr == uart_baud_pkg::OFS_SHARED_HIGH && !div_open |=>
         irq_enable_write && irq_enable_data == $past(wdata[9:0]);
   endproperty
   a_ier_map: assert property (p_ier_map) else $error("enable write not passed on");
   property p_no_ier_open;
      wr_strobe && addr == uart_baud_pkg::OFS_SHARED_HIGH && div_open |=> !irq_enable_write;
   endproperty
   a_no_ier_open: assert property (p_no_ier_open) else $error("enable write while divisor open");
   property p_frac_read;
      rd_strobe && addr == uart_baud_pkg::OFS_FRAC_PRESC |=> rdata[31:8] == 24'h000000;
   endproperty
   a_frac_read: assert property (p_frac_read) else $error("reserved fraction bits not zero");
   property p_tick_after_pre;
      baud16_tick |-> $past(prescale_tick);
   endproperty
   a_tick_after_pre: assert property (p_tick_after_pre) else $error("baud tick without prescale");
   property p_bypass;
      (frac_add_r == 4'h0) [*3] |-> prescale_tick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("prescaler stalls with add zero");
   property p_frac_gap;
      !prescale_tick |=> prescale_tick;
   endproperty
   a_frac_gap: assert property (p_frac_gap) else $error("two stall cycles in a row");
endmodule

bind uart_fractional_baud_generator uart_baud_props i_props (
   .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
   .rd_strobe(rd_strobe), .rdata(rdata), .rbr_read(rbr_read), .rbr_data(rbr_data),
   .thr_write(thr_write), .thr_data(thr_data), .line_control(line_control),
   .irq_enable_write(irq_enable_write), .irq_enable_data(irq_enable_data),
   .prescale_tick(prescale_tick), .baud16_tick(baud16_tick)
);

// ==== tb_top.sv ====
`timescale 1ns/1ps

// ==========================================================
// Testbench
// ==========================================================
module tb_top;
   logic        clock     = 1'b0;          // Peripheral clock
   logic        reset     = 1'b1;          // Synchronous reset
   logic [31:0] addr      = 32'h00000000;  // Access address
   logic [31:0] wdata     = 32'h00000000;  // Write data
   logic        wr_strobe = 1'b0;          // Write request
   logic        rd_strobe = 1'b0;          // Read request
   logic [7:0]  rbr_data  = 8'h3C;         // Receive byte offered
   logic [9:0]  irq_rd    = 10'h2C3;       // Enable bits offered
   logic [31:0] rdata;                     // Read data
   logic        baud16_tick;               // Sampling enable
   logic [7:0]  thr_byte;                  // Forwarded transmit byte
   logic [9:0]  irq_wr_data;               // Forwarded enable bits
   logic [31:0] got;                       // Last read value
   int          n;                         // Measured cycles
   int          fails     = 0;             // Mismatch count
   int          tests_run = 0;             // Comparison count

   typedef struct { logic [7:0] lcr; logic [31:0] a; logic [31:0] d; logic [31:0] e; } row_t;
   typedef struct { logic [7:0] h; logic [7:0] l; logic [3:0] ad; logic [3:0] mu; int e; } baud_t;

   // Register rows: line control, address, write data, expected read
   row_t rows [7] = '{
      '{8'h83, uart_baud_pkg::OFS_LINE_CONTROL, 32'h00000083, 32'h00000083},
      '{8'h80, uart_baud_pkg::OFS_SHARED_LOW, 32'h0000005A, 32'h0000005A},
      '{8'h80, uart_baud_pkg::OFS_SHARED_HIGH, 32'h000000A5, 32'h000000A5},
      '{8'h00, uart_baud_pkg::OFS_SHARED_LOW, 32'h000000C7, 32'h0000003C},
      '{8'h00, uart_baud_pkg::OFS_SHARED_HIGH, 32'h000003FF, 32'h000002C3},
      '{8'h00, uart_baud_pkg::OFS_FRAC_PRESC, 32'hFFFFFF85, 32'h00000085},
      '{8'h00, 32'hE000C100, 32'h12345678, 32'h00000000}};
   // Baud rows: high, low, add, multiplier, cycles per multiplier ticks
   baud_t bauds [6] = '{
      '{8'h00, 8'h00, 4'h0, 4'h1, 1}, '{8'h00, 8'h02, 4'h0, 4'h1, 2},
      '{8'h01, 8'h00, 4'h0, 4'h1, 256}, '{8'h00, 8'h04, 4'h5, 4'h8, 52},
      '{8'h00, 8'h03, 4'hE, 4'hF, 87}, '{8'h00, 8'h05, 4'h0, 4'hF, 75}};

   // Clock at 100 MHz
   always #5 clock = ~clock;

   uart_fractional_baud_generator i_dut (
      .clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rdata(rdata), .rbr_read(), .rbr_data(rbr_data), .thr_write(),
      .thr_data(thr_byte), .irq_enable_write(), .irq_enable_data(irq_wr_data), .irq_enable_rdata(irq_rd),
      .line_control(), .prescale_tick(), .baud16_tick(baud16_tick));

   // One-cycle register write
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      wr_strobe <= 1'b1;
      addr      <= a;
      wdata     <= d;
      @(posedge clock);
      wr_strobe <= 1'b0;
   endtask

   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clock);
      rd_strobe <= 1'b1;
      addr      <= a;
      @(posedge clock);
      rd_strobe <= 1'b0;
      @(posedge clock);
      d = rdata;
   endtask

   // Register value compare
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t read %h expected %h", $time, g, e);
      end
   endtask

   // Cycle count compare
   task automatic chk_cyc(input int g, input int e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t period %0d expected %0d", $time, g, e);
      end
   endtask

   // Cycles up to the next sampling enable, bounded
   task automatic gap(output int c);
      c = 0;
      do begin
         @(posedge clock);
         c++;
      end while (baud16_tick !== 1'b1 && c < 3000);
   endtask

   // Verdict and end of run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      fails++;
      print_verdict();
   end

   // Main sequence
   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      foreach (rows[i]) begin
         wr(uart_baud_pkg::OFS_LINE_CONTROL, {24'h000000, rows[i].lcr});
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, got);
         chk_reg(got, rows[i].e);
         $display("register row %0d done", i);
      end
      // Data path writes left the divisor alone
      wr(uart_baud_pkg::OFS_LINE_CONTROL, 32'h00000080);
      rd(uart_baud_pkg::OFS_SHARED_LOW, got);
      chk_reg(got, 32'h0000005A);
      chk_reg({24'h000000, thr_byte}, 32'h000000C7);
      chk_reg({22'h000000, irq_wr_data}, 32'h000003FF);
      $display("divisor gating done");
      // Reset in mid-run
      @(posedge clock);
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      rd(uart_baud_pkg::OFS_LINE_CONTROL, got);
      chk_reg(got, 32'h00000000);
      rd(uart_baud_pkg::OFS_FRAC_PRESC, got);
      chk_reg(got, 32'h00000010);
      rd(uart_baud_pkg::OFS_BAUD_STATUS, got);
      chk_reg(got, 32'h00000001);
      wr(uart_baud_pkg::OFS_LINE_CONTROL, 32'h00000080);
      rd(uart_baud_pkg::OFS_SHARED_LOW, got);
      chk_reg(got, 32'h00000001);
      rd(uart_baud_pkg::OFS_SHARED_HIGH, got);
      chk_reg(got, 32'h00000000);
      $display("reset values done");
      // Baud periods over a whole fraction cycle
      foreach (bauds[i]) begin
         wr(uart_baud_pkg::OFS_LINE_CONTROL, 32'h00000080);
         wr(uart_baud_pkg::OFS_SHARED_LOW, {24'h000000, bauds[i].l});
         wr(uart_baud_pkg::OFS_SHARED_HIGH, {24'h000000, bauds[i].h});
         wr(uart_baud_pkg::OFS_FRAC_PRESC, {24'h000000, bauds[i].mu, bauds[i].ad});
         wr(uart_baud_pkg::OFS_LINE_CONTROL, 32'h00000000);
         repeat (3) gap(n);
         got = 32'h00000000;
         repeat (bauds[i].mu) begin
            gap(n);
            got = got + 32'(n);
         end
         chk_cyc(int'(got), bauds[i].e);
         $display("baud row %0d done", i);
      end
      print_verdict();
   end
endmodule
